// File: clk_sel_defs.vh
// constants for the cpu clock select and oscillator monitor
`ifndef CLK_SEL_DEFS_VH
`define CLK_SEL_DEFS_VH

// register offsets (byte addresses)
`define SYS_CFG_ADDR     4'h0
`define IRQ_STAT_ADDR    4'h4
`define IRQ_MASK_ADDR    4'h8
`define CLK_STATE_ADDR   4'hC

// field positions
`define MON_DIS_BIT      4
`define FAIL_IRQ_BIT     0

// reset values
`define SYS_CFG_RST      8'h00
`define IRQ_MASK_RST     1'b0

// clock mode codes
`define MODE_X4          3'h7
`define MODE_X3          3'h6
`define MODE_X2          3'h5
`define MODE_X5          3'h4
`define MODE_DIRECT      3'h3
`define MODE_X1P5        3'h2
`define MODE_PRESCALE    3'h1
`define MODE_X2P5        3'h0

// twice the multiplication factor per pll mode
`define MULT2_X4         5'h08
`define MULT2_X3         5'h06
`define MULT2_X2         5'h04
`define MULT2_X5         5'h0A
`define MULT2_X1P5       5'h03
`define MULT2_X2P5       5'h05

// monitor overflow after this many pll cycles without an input edge
`define MON_LIMIT        5'h10

// free-running pll half period in core clock cycles
`define PLL_FREE_HALF    4'h2

`endif

// File: cpu_clock_select.v
// cpu clock source select, pll model and oscillator monitor
`timescale 1ns/1ps
`default_nettype none
`include "clk_sel_defs.vh"

module cpu_clock_select (
    input  wire        core_clk,          // 40 mhz core clock
    input  wire        rst_n,             // async reset, active low
    input  wire        ce,                // clock enable, freezes state when low
    input  wire        osc_input_pin,     // oscillator input, asynchronous
    input  wire [2:0]  clock_config_pins, // mode strap pins
    input  wire [3:0]  addr,              // register byte address
    input  wire [7:0]  wdata,             // register write data
    input  wire        wr,                // write strobe
    input  wire        rd,                // read strobe
    output reg  [7:0]  rdata,             // read data, cycle after rd
    output reg         cpu_clk,           // generated cpu clock
    output reg         cpu_edge,          // pulse on each cpu clock edge
    output wire        pll_on,            // pll powered
    output reg         clock_fail,        // switched to pll after failure
    output wire        irq                // level interrupt
);

    reg  [2:0]  mode;
    reg         mode_taken;
    reg  [1:0]  fill;
    wire [2:0]  cfg_s2;
    wire [2:0]  cfg_s3;
    wire        osc_s2;
    wire        osc_s3;
    reg         osc_lvl;
    reg  [7:0]  sys_cfg;
    reg         fail_stat;
    reg         fail_mask;
    reg  [3:0]  pll_div;
    reg         pll_clk;
    reg  [4:0]  mon_cnt;
    reg  [15:0] per_cnt;
    reg  [15:0] period;
    reg  [15:0] acc;
    reg  [4:0]  edge_cnt;
    reg         pll_out;
    reg         next_cpu_clk;
    reg  [4:0]  mult2;
    reg  [7:0]  next_rdata;

    wire        osc_change = (osc_s2 == osc_s3) && (osc_s3 != osc_lvl);
    wire        osc_rise   = osc_change && osc_s3;
    wire        pll_mode   = (mode != `MODE_DIRECT) && (mode != `MODE_PRESCALE);
    wire        mon_dis    = sys_cfg[`MON_DIS_BIT];
    wire        mon_on     = mode_taken && !pll_mode && !mon_dis;
    wire        pll_tick   = (pll_div == `PLL_FREE_HALF - 4'h1);
    wire        pll_rise   = pll_tick && !pll_clk;
    wire [15:0] acc_add    = acc + {11'h000, mult2};
    // odd doubled factors need four times the span to end on a whole cpu period
    wire [4:0]  sync_span  = mult2[0] ? {mult2[2:0], 2'b00} : mult2;
    wire        fail_set   = mon_on && pll_rise && (mon_cnt == `MON_LIMIT - 5'h01);

    // pll runs in pll modes, for the monitor, or after a failure
    assign pll_on = mode_taken && (pll_mode || mon_on || clock_fail);
    assign irq    = fail_stat && fail_mask;

    always @* begin
        case (mode)
            `MODE_X4:   mult2 = `MULT2_X4;
            `MODE_X3:   mult2 = `MULT2_X3;
            `MODE_X2:   mult2 = `MULT2_X2;
            `MODE_X5:   mult2 = `MULT2_X5;
            `MODE_X1P5: mult2 = `MULT2_X1P5;
            `MODE_X2P5: mult2 = `MULT2_X2P5;
            default:    mult2 = `MULT2_X4;
        endcase
    end

    // synchronisers: a change counts once stages two and three agree
    sync_stage #(
        .WIDTH (1)
    ) osc_sync_u (
        .clk   (core_clk),
        .rst_n (rst_n),
        .en    (ce),
        .din   (osc_input_pin),
        .q2    (osc_s2),
        .q3    (osc_s3)
    );

    sync_stage #(
        .WIDTH (3)
    ) cfg_sync_u (
        .clk   (core_clk),
        .rst_n (rst_n),
        .en    (ce),
        .din   (clock_config_pins),
        .q2    (cfg_s2),
        .q3    (cfg_s3)
    );

    // settled input level, moves only when the last two stages agree
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_lvl <= 1'b0;
        end else if (ce) begin
            if (osc_s2 == osc_s3) begin
                osc_lvl <= osc_s3;
            end
        end
    end

    // mode strap caught once after reset release, then frozen
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fill       <= 2'h0;
            mode_taken <= 1'b0;
            mode       <= `MODE_X4;
        end else if (ce && !mode_taken) begin
            if (fill == 2'h3) begin
                if (cfg_s2 == cfg_s3) begin
                    mode       <= cfg_s3;
                    mode_taken <= 1'b1;
                end
            end else begin
                fill <= fill + 2'h1;
            end
        end
    end

    // free-running pll oscillator model
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_div <= 4'h0;
            pll_clk <= 1'b0;
        end else if (ce) begin
            if (!pll_on) begin
                // powered down: hold the divider at its start point
                pll_div <= 4'h0;
                pll_clk <= 1'b0;
            end else if (pll_tick) begin
                pll_div <= 4'h0;
                pll_clk <= !pll_clk;
            end else begin
                pll_div <= pll_div + 4'h1;
            end
        end
    end

    // oscillator monitor
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mon_cnt    <= 5'h00;
            clock_fail <= 1'b0;
        end else if (ce) begin
            if (!mon_on || osc_change) begin
                mon_cnt <= 5'h00;
            end else if (pll_rise && mon_cnt != `MON_LIMIT) begin
                // saturate so a dead input cannot wrap the count back to zero
                mon_cnt <= mon_cnt + 5'h01;
            end
            // only a reset clears the switch-over
            if (fail_set) begin
                clock_fail <= 1'b1;
            end
        end
    end

    // input period measure and multiplied clock for pll modes
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt  <= 16'h0000;
            period   <= 16'h0000;
            acc      <= 16'h0000;
            edge_cnt <= 5'h00;
            pll_out  <= 1'b0;
        end else if (ce) begin
            // input period in core cycles, rising edge to rising edge
            if (osc_rise) begin
                per_cnt <= 16'h0001;
                period  <= per_cnt;
            end else if (per_cnt != 16'hFFFF) begin
                per_cnt <= per_cnt + 16'h0001;
            end
            if (osc_change && edge_cnt >= sync_span - 5'h01) begin
                // realign phase after a whole number of cpu periods
                edge_cnt <= 5'h00;
                acc      <= 16'h0000;
                pll_out  <= 1'b1;
            end else begin
                if (osc_change) begin
                    edge_cnt <= edge_cnt + 5'h01;
                end
                // accumulator toggles the output 2F times per input period
                if (period != 16'h0000 && acc_add >= period) begin
                    acc     <= acc_add - period;
                    pll_out <= !pll_out;
                end else begin
                    acc <= acc_add;
                end
            end
        end
    end

    // cpu clock source: pll after a failure, else the strapped mode
    always @* begin
        next_cpu_clk = pll_out;
        if (clock_fail) begin
            next_cpu_clk = pll_clk;
        end else begin
            case (mode)
                `MODE_DIRECT: begin
                    next_cpu_clk = osc_lvl;
                end
                `MODE_PRESCALE: begin
                    next_cpu_clk = osc_rise ? !cpu_clk : cpu_clk;
                end
                default: begin
                    next_cpu_clk = pll_out;
                end
            endcase
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_clk  <= 1'b0;
            cpu_edge <= 1'b0;
        end else if (ce) begin
            cpu_clk  <= mode_taken ? next_cpu_clk : 1'b0;
            cpu_edge <= mode_taken && (next_cpu_clk != cpu_clk);
        end
    end

    // system configuration: bit 4 turns the monitor off
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_cfg <= `SYS_CFG_RST;
        end else if (ce) begin
            if (wr && addr == `SYS_CFG_ADDR) begin
                sys_cfg <= wdata;
            end
        end
    end

    // interrupt mask
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fail_mask <= `IRQ_MASK_RST;
        end else if (ce) begin
            if (wr && addr == `IRQ_MASK_ADDR) begin
                fail_mask <= wdata[`FAIL_IRQ_BIT];
            end
        end
    end

    // sticky failure status: a new failure beats a clear in the same cycle
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fail_stat <= 1'b0;
        end else if (ce) begin
            if (fail_set) begin
                fail_stat <= 1'b1;
            end else if (wr && addr == `IRQ_STAT_ADDR && wdata[`FAIL_IRQ_BIT]) begin
                fail_stat <= 1'b0;
            end
        end
    end

    always @* begin
        case (addr)
            `SYS_CFG_ADDR:   next_rdata = sys_cfg;
            `IRQ_STAT_ADDR:  next_rdata = {7'h00, fail_stat};
            `IRQ_MASK_ADDR:  next_rdata = {7'h00, fail_mask};
            `CLK_STATE_ADDR: next_rdata = {2'h0, pll_on, clock_fail, mode_taken, mode};
            default:         next_rdata = 8'h00;
        endcase
    end

    // read data stand for one cycle after the strobe, zero otherwise
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= rd ? next_rdata : 8'h00;
        end
    end

endmodule // cpu_clock_select

// three-stage synchroniser, second and third stages exposed for agreement
module sync_stage #(
    parameter WIDTH = 1
) (
    input  wire             clk,   // sampling clock
    input  wire             rst_n, // async reset, active low
    input  wire             en,    // clock enable
    input  wire [WIDTH-1:0] din,   // asynchronous input
    output wire [WIDTH-1:0] q2,    // second stage
    output wire [WIDTH-1:0] q3     // third stage
);

    reg  [WIDTH-1:0] s1;
    reg  [WIDTH-1:0] s2;
    reg  [WIDTH-1:0] s3;

    assign q2 = s2;
    assign q3 = s3;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= {WIDTH{1'b0}};
            s2 <= {WIDTH{1'b0}};
            s3 <= {WIDTH{1'b0}};
        end else if (en) begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

endmodule // sync_stage
`default_nettype wire

// File: cpu_clock_select_asserts.sv
// assertions on the ports of the cpu clock select block
`timescale 1ns/1ps
`default_nettype none
module clk_sel_checker (
    input wire logic       core_clk,      // clock
    input wire logic       rst_n,         // reset
    input wire logic       ce,            // enable
    input wire logic       osc_input_pin, // osc in
    input wire logic       rd,            // read
    input wire logic [7:0] rdata,         // data
    input wire logic       cpu_clk,       // cpu clk
    input wire logic       cpu_edge,      // edge
    input wire logic       pll_on,        // pll
    input wire logic       clock_fail     // failed
);
    logic       osc_q;
    logic [7:0] quiet;
    // cycles since the input pin last moved
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_q <= 1'b0;
            quiet <= 8'h00;
        end else begin
            osc_q <= osc_input_pin;
            quiet <= (osc_q != osc_input_pin) ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_fail_run;
        (clock_fail && ce) [*5];
    endsequence
    a_edge_marks: assert property ($past(ce) |-> cpu_edge == (cpu_clk != $past(cpu_clk)))
        else $error("edge pulse wrong");
    a_ce_freeze: assert property (!ce |=> $stable(cpu_clk) && $stable(clock_fail))
        else $error("state moved while frozen");
    a_fail_held: assert property (clock_fail |=> clock_fail)
        else $error("failover dropped");
    a_fail_pll_on: assert property (clock_fail |-> pll_on)
        else $error("pll off after failover");
    a_fail_early: assert property ($rose(clock_fail) |-> quiet >= 8'h3C && $past(pll_on))
        else $error("failover too early");
    a_rd_idle: assert property ($past(ce) && !$past(rd) |-> rdata == 8'h00)
        else $error("read data outside slot");
    a_fail_pll_clk: assert property (s_fail_run |-> cpu_edge || $past(cpu_edge) || $past(cpu_edge, 2))
        else $error("cpu clock not on pll");
    a_reset_start: assert property ($rose(rst_n) |-> !cpu_clk && !clock_fail)
        else $error("bad state after reset");
endmodule // clk_sel_checker
bind cpu_clock_select clk_sel_checker chk_u (.core_clk, .rst_n, .ce, .osc_input_pin, .rd,
    .rdata, .cpu_clk, .cpu_edge, .pll_on, .clock_fail);
`default_nettype wire

// File: cpu_clock_select_osc_monitor_bench.sv
// self-checking bench for the cpu clock select block
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_select_osc_monitor_bench;
    logic       core_clk, rst_n, ce, wr, rd, run, osc, cpu_clk, cpu_edge, pll_on, clock_fail, irq;
    logic [2:0] pins;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    int         err_total, tests_run, cyc, seed, ne, nh, i;
    int         per_in[8] = '{5, 1, 3, 2, 10, 4, 6, 8}; // cpu edges per input period
    cpu_clock_select dut_u (.core_clk, .rst_n, .ce, .osc_input_pin(osc), .clock_config_pins(pins),
        .addr, .wdata, .wr, .rd, .rdata, .cpu_clk, .cpu_edge, .pll_on, .clock_fail, .irq);
    osc_source_model osc_u (.run, .osc);
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input bit ok, input string msg);
        tests_run++;
        if (!ok) begin
            err_total++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 9000) begin
            err_total++;
            end_of_test;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 chk(rdata === e, "read data");
    endtask
    task automatic do_reset(input logic [2:0] c);
        rst_n <= 1'b0;
        pins <= c;
        run <= 1'b1;
        tick(3);
        rst_n <= 1'b1;
        tick(8);
    endtask
    initial begin
        {rst_n, ce, wr, rd, run, addr, wdata, pins} = '0;
        ce = 1'b1;
        seed = 43;
        for (int c = 0; c < 8; c++) begin
            do_reset(c[2:0]);
            tick(70);
            pins <= 3'($random(seed));
            ne = 0;
            nh = 0;
            repeat (320) begin
                @(posedge core_clk);
                #1;
                ne += int'(cpu_edge === 1'b1);
                nh += int'(cpu_clk === 1'b1);
            end
            chk(ne >= 20 * per_in[c] - 4 && ne <= 20 * per_in[c] + 4, "edge rate");
            if (c == 3) chk(nh >= 110 && nh <= 130, "direct high time");
            if (c == 1) chk(nh >= 144 && nh <= 176, "prescale high time");
            rd_chk(4'hC, 8'h28 | {5'h00, c[2:0]});
            $display("mode %0d test done", c);
        end
        do_reset(3'h3);
        rd_chk(4'h0, 8'h00);
        rd_chk(4'h4, 8'h00);
        rd_chk(4'h8, 8'h00);
        rd_chk(4'h2, 8'h00);
        run <= 1'b0;
        tick(30);
        run <= 1'b1;
        tick(80);
        chk(clock_fail === 1'b0, "short gap failed over");
        run <= 1'b0;
        for (i = 0; i < 120 && clock_fail !== 1'b1; i++) tick(1);
        chk(clock_fail === 1'b1 && irq === 1'b0, "no failover");
        rd_chk(4'h4, 8'h01);
        run <= 1'b1;
        tick(100);
        rd_chk(4'h4, 8'h01);
        chk(clock_fail === 1'b1, "returned to input");
        wr_reg(4'h8, 8'h01);
        #1 chk(irq === 1'b1, "irq not raised");
        ce <= 1'b0;
        tick(1 + ($random(seed) & 3));
        ce <= 1'b1;
        wr_reg(4'h4, 8'h01);
        #1 chk(irq === 1'b0, "irq not cleared");
        rd_chk(4'h4, 8'h00);
        $display("failover test done");
        do_reset(3'h3);
        wr_reg(4'h0, 8'h10);
        rd_chk(4'h0, 8'h10);
        chk(pll_on === 1'b0, "pll still on");
        run <= 1'b0;
        tick(150);
        chk(clock_fail === 1'b0, "failover while disabled");
        do_reset(3'h7);
        run <= 1'b0;
        tick(150);
        chk(clock_fail === 1'b0 && pll_on === 1'b1, "failover in pll mode");
        $display("monitor idle test done");
        end_of_test;
    end
endmodule // cpu_clock_select_osc_monitor_bench
`default_nettype wire

// File: osc_source_model.sv
// oscillator source at the far side, able to stop mid-run
`timescale 1ns/1ps
`default_nettype none
module osc_source_model #(
    parameter int HI_NS = 150,
    parameter int LO_NS = 250
) (
    input  wire logic run, // oscillate while high
    output var  logic osc  // to the oscillator input pin
);
    // a stopped source holds its last level
    initial begin
        osc = 1'b0;
        forever begin
            #(LO_NS);
            if (run) osc = 1'b1;
            #(HI_NS);
            if (run) osc = 1'b0;
        end
    end
endmodule // osc_source_model
`default_nettype wire
